/* File: design/gsp_port.sv */
// module: sixteen-pin general-purpose port with configuration bus slave
`timescale 1ns/10ps
module gsp_port
#(
	parameter int unsigned W = 16
)
(
	// clock, reset, enable
	input  wire logic                 clk_sys,
	input  wire logic                 nrst,
	input  wire logic                 ce,
	// configuration bus
	input  wire logic                 cfg_valid,
	input  wire gsp_pkg::gsp_cfg_req_s cfg_req,
	output logic                      cfg_ack,
	output logic [31:0]               cfg_rdata,
	// port pins
	input  wire logic [W-1:0]         port_pins_in,
	output logic      [W-1:0]         port_pins_out,
	output logic      [W-1:0]         port_pins_oe,
	// requests
	output logic                      cpu_irq,
	output logic                      dma_event
);
	import gsp_pkg::*;

	logic [W-1:0] pin_enable;
	logic [W-1:0] pin_direction;
	logic [W-1:0] pin_value;
	logic [W-1:0] rising_transition_mask;
	logic [W-1:0] falling_transition_mask;
	logic [1:0]   port_global_control;
	logic         interrupt_polarity;
	logic [W-1:0] rising_transition_flags;
	logic [W-1:0] falling_transition_flags;
	logic [W-1:0] port_input_level;
	logic [W-1:0] drive_sel;
	logic [W-1:0] read_value;
	logic [W-1:0] rise_clr;
	logic [W-1:0] fall_clr;
	logic [31:0]  next_rdata;
	logic         wr_go;
	logic         evt;
	logic         evt_d;

	//----------------------------------------------------------------
	// pin input path
	//----------------------------------------------------------------

	// the outside must hold a level long enough to cross two stages
	gsp_sync #(.W(W)) u_sync
	(
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.ce       (ce),
		.async_in (port_pins_in),
		.sync_out (port_input_level)
	);

	// a pin is driven only when enabled and set to output
	assign drive_sel = pin_enable & pin_direction;
	// inputs and disabled pins read the live level, enabled outputs read back the written value
	assign read_value = (drive_sel & pin_value)
		| (~drive_sel & port_input_level);

	//----------------------------------------------------------------
	// register writes
	//----------------------------------------------------------------

	assign wr_go = ce && cfg_valid && cfg_req.wr;

	// control registers; direction resets to all inputs
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_enable <= RST_PIN_ENABLE;
			pin_direction <= RST_PIN_DIRECTION;
			pin_value <= RST_PIN_VALUE;
		end
		else if (wr_go)
		begin
			case (cfg_req.addr)
				ADDR_PIN_ENABLE: pin_enable <= cfg_req.wdata[W-1:0];
				ADDR_PIN_DIRECTION: pin_direction <= cfg_req.wdata[W-1:0];
				ADDR_PIN_VALUE: pin_value <= cfg_req.wdata[W-1:0];
				default: ;
			endcase
		end
	end

	// masks and mode selection
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rising_transition_mask <= RST_MASK;
			falling_transition_mask <= RST_MASK;
			port_global_control <= RST_GLOBAL_CTRL;
			interrupt_polarity <= RST_POLARITY;
		end
		else if (wr_go)
		begin
			case (cfg_req.addr)
				ADDR_RISE_MASK: rising_transition_mask <= cfg_req.wdata[W-1:0];
				ADDR_FALL_MASK: falling_transition_mask <= cfg_req.wdata[W-1:0];
				ADDR_GLOBAL_CTRL: port_global_control <= cfg_req.wdata[1:0];
				ADDR_POLARITY:
					interrupt_polarity <= cfg_req.wdata[POL_INVERT_BIT];
				default: ;
			endcase
		end
	end

	// writing a one clears a flag bit
	assign rise_clr = (wr_go && cfg_req.addr == ADDR_RISE_FLAGS)
		? cfg_req.wdata[W-1:0] : '0;
	assign fall_clr = (wr_go && cfg_req.addr == ADDR_FALL_FLAGS)
		? cfg_req.wdata[W-1:0] : '0;

	//----------------------------------------------------------------
	// transition detection and request generation
	//----------------------------------------------------------------

	// only enabled pins are watched for edges
	gsp_event #(.W(W)) u_event
	(
		.clk_sys    (clk_sys),
		.nrst       (nrst),
		.ce         (ce),
		.lvl        (port_input_level),
		.watch      (pin_enable),
		.rise_clr   (rise_clr),
		.fall_clr   (fall_clr),
		.rise_mask  (rising_transition_mask),
		.fall_mask  (falling_transition_mask),
		.gctrl      (port_global_control),
		.invert     (interrupt_polarity),
		.rise_flags (rising_transition_flags),
		.fall_flags (falling_transition_flags),
		.evt        (evt)
	);

	// interrupt is a level, dma request a pulse on each new event
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			evt_d <= 1'b0;
			cpu_irq <= 1'b0;
			dma_event <= 1'b0;
		end
		else if (ce)
		begin
			evt_d <= evt;
			cpu_irq <= evt;
			dma_event <= evt && !evt_d;
		end
	end

	//----------------------------------------------------------------
	// pin drivers
	//----------------------------------------------------------------

	// registered so the pads see clean edges; costs one cycle
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			port_pins_oe <= '0;
			port_pins_out <= '0;
		end
		else if (ce)
		begin
			port_pins_oe <= drive_sel;
			port_pins_out <= pin_value & drive_sel;
		end
	end

	//----------------------------------------------------------------
	// register reads
	//----------------------------------------------------------------

	// unmapped addresses read zero; bits above the port read zero
	always_comb
	begin
		next_rdata = 32'h00000000;
		case (cfg_req.addr)
			ADDR_PIN_ENABLE: next_rdata[W-1:0] = pin_enable;
			ADDR_PIN_DIRECTION: next_rdata[W-1:0] = pin_direction;
			ADDR_PIN_VALUE: next_rdata[W-1:0] = read_value;
			ADDR_RISE_FLAGS: next_rdata[W-1:0] = rising_transition_flags;
			ADDR_RISE_MASK: next_rdata[W-1:0] = rising_transition_mask;
			ADDR_FALL_FLAGS: next_rdata[W-1:0] = falling_transition_flags;
			ADDR_FALL_MASK: next_rdata[W-1:0] = falling_transition_mask;
			ADDR_GLOBAL_CTRL: next_rdata[1:0] = port_global_control;
			ADDR_POLARITY: next_rdata[POL_INVERT_BIT] = interrupt_polarity;
			default: next_rdata = 32'h00000000;
		endcase
	end

	// one answer per request, one cycle later
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			cfg_ack <= 1'b0;
			cfg_rdata <= 32'h00000000;
		end
		else if (ce)
		begin
			cfg_ack <= cfg_valid;
			cfg_rdata <= (cfg_valid && !cfg_req.wr) ? next_rdata : 32'h0;
		end
	end

	//----------------------------------------------------------------
	// checks
	//----------------------------------------------------------------

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	a_dir_after_reset: assert property (
		!$past(nrst) |-> (pin_direction == '0 && port_pins_oe == '0))
		else $error("pin driven after reset");
	a_oe_needs_enable: assert property (
		$past(ce) |-> (port_pins_oe & ~$past(pin_enable)) == '0)
		else $error("disabled pin driven");
	a_oe_follows_dir: assert property (
		$past(ce) |-> port_pins_oe == $past(pin_enable & pin_direction))
		else $error("output enable does not match direction");
	a_dir_ignored: assert property (
		(ce && pin_enable == '0) |=> port_pins_oe == '0)
		else $error("direction acts on disabled pins");
	a_out_follows_val: assert property (
		(wr_go && cfg_req.addr == ADDR_PIN_VALUE) ##1 ce
		|=> ((port_pins_out ^ $past(cfg_req.wdata[W-1:0], 2))
		& port_pins_oe) == '0)
		else $error("output level differs from written value");
	a_read_input: assert property (
		(ce && cfg_valid && !cfg_req.wr && cfg_req.addr == ADDR_PIN_VALUE)
		|=> ((cfg_rdata[W-1:0] ^ $past(port_input_level))
		& ~$past(drive_sel)) == '0)
		else $error("input read does not show pin level");
	a_dma_pulse: assert property (
		(dma_event && ce) |=> !dma_event)
		else $error("dma request longer than one cycle");
	a_irq_quiet: assert property (
		(ce && evt == 1'b0) |=> !cpu_irq)
		else $error("interrupt without event");
	a_flags_high_word: assert property (
		cfg_ack |-> cfg_rdata[31:W] == '0)
		else $error("unused high bits read nonzero");
	a_ack_timing: assert property (
		(ce && cfg_valid) |=> cfg_ack)
		else $error("missing bus answer");

	// bus writes land in the addressed register at the taking edge
	a_enable_lands: assert property (
		(wr_go && cfg_req.addr == ADDR_PIN_ENABLE)
		|=> pin_enable == $past(cfg_req.wdata[W-1:0]))
		else $error("enable write lost");
	a_dir_lands: assert property (
		(wr_go && cfg_req.addr == ADDR_PIN_DIRECTION)
		|=> pin_direction == $past(cfg_req.wdata[W-1:0]))
		else $error("direction write lost");
	a_value_lands: assert property (
		(wr_go && cfg_req.addr == ADDR_PIN_VALUE)
		|=> pin_value == $past(cfg_req.wdata[W-1:0]))
		else $error("value write lost");
	a_rdata_on_write: assert property (
		(ce && cfg_valid && cfg_req.wr) |=> cfg_rdata == 32'h00000000)
		else $error("write answered with data");

	// flag clears: a steady synchronised level cannot refill a bit,
	// so the cleared bits must read zero one cycle later
	a_rise_clear: assert property (
		(wr_go && cfg_req.addr == ADDR_RISE_FLAGS && $past(ce)
		&& $stable(port_input_level))
		|=> (rising_transition_flags
		& $past(cfg_req.wdata[W-1:0])) == '0)
		else $error("rising flag not cleared");
	a_fall_clear: assert property (
		(wr_go && cfg_req.addr == ADDR_FALL_FLAGS && $past(ce)
		&& $stable(port_input_level))
		|=> (falling_transition_flags
		& $past(cfg_req.wdata[W-1:0])) == '0)
		else $error("falling flag not cleared");

	// new flag bits only ever appear on enabled pins
	a_flag_needs_en: assert property (
		ce |=> (((rising_transition_flags
		& ~$past(rising_transition_flags))
		| (falling_transition_flags
		& ~$past(falling_transition_flags)))
		& ~$past(pin_enable)) == '0)
		else $error("flag set on disabled pin");

	// in edge mode, polarity alone raises the request when nothing is flagged
	a_pol_inverts: assert property (
		(ce && interrupt_polarity && port_global_control == 2'h0
		&& rising_transition_flags == '0
		&& falling_transition_flags == '0)
		|=> cpu_irq)
		else $error("polarity does not invert the request");

	// a low enable must freeze everything the bus and pins can see
	a_ce_freeze: assert property (
		!ce |=> ($stable(cfg_ack) && $stable(cfg_rdata)
		&& $stable(cpu_irq) && $stable(dma_event)
		&& $stable(port_pins_oe) && $stable(port_pins_out)))
		else $error("outputs moved while clock enable low");

	c_output_driven: cover property (|port_pins_oe ##1 |port_pins_out);
	c_irq_from_edge: cover property (|rising_transition_flags ##[1:4] cpu_irq);
	c_dma_pulse: cover property (dma_event);
	c_input_read: cover property (cfg_ack && |cfg_rdata[W-1:0]);
	c_and_mode: cover property (port_global_control == 2'h3 && cpu_irq);
endmodule

/* File: design/gsp_pkg.sv */
// package: register map, reset values, fields and types of the gpio port
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package gsp_pkg;

	localparam int unsigned NPINS = 16;

	// register addresses on the configuration bus
	localparam logic [31:0] ADDR_PIN_ENABLE = 32'h01b00000;
	localparam logic [31:0] ADDR_PIN_DIRECTION = 32'h01b00004;
	localparam logic [31:0] ADDR_PIN_VALUE = 32'h01b00008;
	localparam logic [31:0] ADDR_RISE_FLAGS = 32'h01b00010;
	localparam logic [31:0] ADDR_RISE_MASK = 32'h01b00014;
	localparam logic [31:0] ADDR_FALL_FLAGS = 32'h01b00018;
	localparam logic [31:0] ADDR_FALL_MASK = 32'h01b0001c;
	localparam logic [31:0] ADDR_GLOBAL_CTRL = 32'h01b00020;
	localparam logic [31:0] ADDR_POLARITY = 32'h01b00024;

	// reset values
	localparam logic [15:0] RST_PIN_ENABLE = 16'h0000;
	localparam logic [15:0] RST_PIN_DIRECTION = 16'h0000;
	localparam logic [15:0] RST_PIN_VALUE = 16'h0000;
	localparam logic [15:0] RST_MASK = 16'h0000;
	localparam logic [1:0] RST_GLOBAL_CTRL = 2'h0;
	localparam logic RST_POLARITY = 1'b0;

	// global control fields
	localparam int unsigned GC_LOGIC_BIT = 0; // 0 edge mode, 1 level logic
	localparam int unsigned GC_AND_BIT = 1; // logic mode: 0 or, 1 and
	localparam int unsigned POL_INVERT_BIT = 0;

	// timing: outside hold times in cpu periods, our clock period
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned EVT_HOLD_PERIODS = 8;
	localparam int unsigned POLL_HOLD_PERIODS = 12;
	localparam int unsigned SYNC_STAGES = 2;

	typedef struct packed
	{
		logic        wr;
		logic [31:0] addr;
		logic [31:0] wdata;
	} gsp_cfg_req_s;

endpackage

/* File: design/gsp_sync.sv */
// module: two-stage synchroniser for the port pin inputs
`timescale 1ns/10ps
module gsp_sync
#(
	parameter int unsigned W = 16
)
(
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic         ce,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	import gsp_pkg::*;

	logic [W-1:0] meta;

	// first stage is read only by the second stage
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			meta <= '0;
			sync_out <= '0;
		end
		else if (ce)
		begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule

/* File: design/gsp_event.sv */
// module: transition flags, masks and interrupt/event mode logic
`timescale 1ns/10ps
module gsp_event
#(
	parameter int unsigned W = 16
)
(
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic         ce,
	// synchronised levels and pin qualifier
	input  wire logic [W-1:0] lvl,
	input  wire logic [W-1:0] watch,
	// software controls
	input  wire logic [W-1:0] rise_clr,
	input  wire logic [W-1:0] fall_clr,
	input  wire logic [W-1:0] rise_mask,
	input  wire logic [W-1:0] fall_mask,
	input  wire logic [1:0]   gctrl,
	input  wire logic         invert,
	// results
	output logic      [W-1:0] rise_flags,
	output logic      [W-1:0] fall_flags,
	output logic              evt
);
	import gsp_pkg::*;

	logic [W-1:0] lvl_d;
	logic [W-1:0] rise_hit;
	logic [W-1:0] fall_hit;
	logic [W-1:0] sel;
	logic [W-1:0] act;
	logic         raw;

	assign rise_hit = lvl & ~lvl_d & watch;
	assign fall_hit = ~lvl & lvl_d & watch;

	// previous level for edge detection
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			lvl_d <= '0;
		else if (ce)
			lvl_d <= lvl;
	end

	// sticky flags; a new edge wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rise_flags <= '0;
			fall_flags <= '0;
		end
		else if (ce)
		begin
			rise_flags <= (rise_flags & ~rise_clr) | rise_hit;
			fall_flags <= (fall_flags & ~fall_clr) | fall_hit;
		end
	end

	// mode select: masked edge flags, or and/or over masked levels
	always_comb
	begin
		sel = rise_mask | fall_mask;
		act = (lvl & rise_mask) | (~lvl & fall_mask);
		if (!gctrl[GC_LOGIC_BIT])
			raw = |((rise_flags & rise_mask) | (fall_flags & fall_mask));
		else if (gctrl[GC_AND_BIT])
			raw = (|sel) && (&(act | ~sel));
		else
			raw = |act;
		evt = raw ^ invert;
	end

	a_rise_latch: assert property (@(posedge clk_sys) disable iff (!nrst)
		(ce && |rise_hit) |=> |(rise_flags & $past(rise_hit)))
		else $error("rising edge not latched");
	a_fall_latch: assert property (@(posedge clk_sys) disable iff (!nrst)
		(ce && |fall_hit) |=> |(fall_flags & $past(fall_hit)))
		else $error("falling edge not latched");
endmodule

/* File: tb/gsp_board.sv */
// board model: outside sources on the port pins
`timescale 1ns/10ps
module gsp_board
(
	// level the outside source wants on each pin
	input  wire logic [15:0] drv_level,
	// port side of the pins
	input  wire logic [15:0] port_pins_out,
	input  wire logic [15:0] port_pins_oe,
	output logic      [15:0] port_pins_in
);
	// source backs off where the port drives; the bench holds each
	// level at least 12 cycles so both polling and events see it
	assign port_pins_in = (port_pins_oe & port_pins_out) |
		(~port_pins_oe & drv_level);
endmodule

/* File: tb/tb_top.sv */
// testbench: register tasks and pin scenarios for the gpio port
`timescale 1ns/10ps
module tb_top;
	import gsp_pkg::*;

	logic                 clk_sys;
	logic                 nrst;
	logic                 ce;
	logic                 cfg_valid;
	gsp_cfg_req_s         cfg_req;
	logic                 cfg_ack;
	logic [31:0]          cfg_rdata;
	logic [15:0]          pins_in;
	logic [15:0]          pins_out;
	logic [15:0]          pins_oe;
	logic [15:0]          ext;
	logic                 cpu_irq;
	logic                 dma_event;
	logic [31:0]          q;
	logic [31:0]          addrs [10];
	int                   miscompares;
	int                   tests_run;
	int                   cycles;
	int                   dma_cnt;
	int                   d0;

	gsp_port gsp_port_inst
	(
		.clk_sys       (clk_sys),
		.nrst          (nrst),
		.ce            (ce),
		.cfg_valid     (cfg_valid),
		.cfg_req       (cfg_req),
		.cfg_ack       (cfg_ack),
		.cfg_rdata     (cfg_rdata),
		.port_pins_in  (pins_in),
		.port_pins_out (pins_out),
		.port_pins_oe  (pins_oe),
		.cpu_irq       (cpu_irq),
		.dma_event     (dma_event)
	);

	gsp_board gsp_board_inst
	(
		.drv_level     (ext),
		.port_pins_out (pins_out),
		.port_pins_oe  (pins_oe),
		.port_pins_in  (pins_in)
	);

	//----------------------------------------------------------------
	// clock, watchdog, pulse counter
	//----------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// whole run is a few hundred cycles; 5000 means a hang
	always @(posedge clk_sys)
	begin
		cycles++;
		if (dma_event === 1'b1)
			dma_cnt++;
		if (cycles == 5000)
		begin
			miscompares++;
			stop_test();
		end
	end

	//----------------------------------------------------------------
	// tasks
	//----------------------------------------------------------------
	task automatic stop_test();
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h got %h", nm, e, g);
			miscompares++;
		end
	endtask

	// one request; valid drops after the taking edge so it counts once
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		cfg_valid <= 1'b1;
		cfg_req <= '{wr, a, d};
		@(posedge clk_sys);
		cfg_valid <= 1'b0;
		do
		begin
			@(negedge clk_sys);
			n++;
		end
		while (cfg_ack !== 1'b1 && n < 4);
		chk("cfg_ack", 32'h1, {31'h0, cfg_ack});
		q = cfg_rdata;
	endtask

	task automatic rd(input string nm, input logic [31:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask

	// new outside level, held past the polling minimum
	task automatic pins(input logic [15:0] v);
		@(posedge clk_sys);
		ext <= v;
		repeat (14) @(posedge clk_sys);
	endtask

	task automatic irq(input logic e);
		repeat (3) @(negedge clk_sys);
		chk("cpu_irq", {31'h0, e}, {31'h0, cpu_irq});
	endtask

	//----------------------------------------------------------------
	// main sequence
	//----------------------------------------------------------------
	initial
	begin
		nrst = 1'b0;
		ce = 1'b1;
		cfg_valid = 1'b0;
		cfg_req = '0;
		ext = 16'h0000;
		cycles = 0;
		dma_cnt = 0;
		miscompares = 0;
		tests_run = 0;
		addrs = '{ADDR_PIN_ENABLE, ADDR_PIN_DIRECTION, ADDR_PIN_VALUE,
			32'h01b0000c, ADDR_RISE_FLAGS, ADDR_RISE_MASK,
			ADDR_FALL_FLAGS, ADDR_FALL_MASK, ADDR_GLOBAL_CTRL,
			ADDR_POLARITY};
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		@(negedge clk_sys);
		chk("pins_oe", 32'h0, {16'h0, pins_oe});
		foreach (addrs[i])
			rd("reset_value", addrs[i], 32'h0);
		// direction and value set while no pin is enabled
		bus(1'b1, ADDR_PIN_DIRECTION, 32'h00ff);
		bus(1'b1, ADDR_PIN_VALUE, 32'h00a5);
		bus(1'b1, 32'h01b0000c, 32'hffff);
		rd("unmapped", 32'h01b0000c, 32'h0);
		pins(16'h5a00);
		chk("pins_oe", 32'h0, {16'h0, pins_oe});
		bus(1'b1, ADDR_PIN_ENABLE, 32'hfff0);
		@(negedge clk_sys);
		chk("pins_oe", 32'h00f0, {16'h0, pins_oe});
		chk("pins_out", 32'h00a0, {16'h0, pins_out});
		rd("pin_value", ADDR_PIN_VALUE, 32'h5aa0);
		// clear edge history, then one rising edge on pin 9
		pins(16'h0000);
		bus(1'b1, ADDR_RISE_FLAGS, 32'hffff);
		bus(1'b1, ADDR_FALL_FLAGS, 32'hffff);
		bus(1'b1, ADDR_RISE_MASK, 32'h0200);
		irq(1'b0);
		d0 = dma_cnt;
		pins(16'h0200);
		irq(1'b1);
		chk("dma_pulses", 32'h1, 32'(dma_cnt - d0));
		rd("rise_flags", ADDR_RISE_FLAGS, 32'h0200);
		rd("fall_flags", ADDR_FALL_FLAGS, 32'h0);
		bus(1'b1, ADDR_POLARITY, 32'h1);
		rd("polarity", ADDR_POLARITY, 32'h1);
		irq(1'b0);
		bus(1'b1, ADDR_RISE_FLAGS, 32'h0200);
		irq(1'b1);
		bus(1'b1, ADDR_POLARITY, 32'h0);
		irq(1'b0);
		// level logic modes: or, then and over two selected pins
		bus(1'b1, ADDR_GLOBAL_CTRL, 32'h1);
		irq(1'b1);
		bus(1'b1, ADDR_GLOBAL_CTRL, 32'h3);
		rd("global_ctrl", ADDR_GLOBAL_CTRL, 32'h3);
		irq(1'b1);
		bus(1'b1, ADDR_RISE_MASK, 32'h0600);
		rd("rise_mask", ADDR_RISE_MASK, 32'h0600);
		irq(1'b0);
		bus(1'b1, ADDR_GLOBAL_CTRL, 32'h0);
		// falling edge on pin 9; pin 1 is disabled and never flags
		pins(16'h0002);
		rd("fall_flags", ADDR_FALL_FLAGS, 32'h0200);
		rd("rise_flags", ADDR_RISE_FLAGS, 32'h0);
		irq(1'b0);
		bus(1'b1, ADDR_FALL_MASK, 32'h0200);
		rd("fall_mask", ADDR_FALL_MASK, 32'h0200);
		irq(1'b1);
		bus(1'b1, ADDR_FALL_FLAGS, 32'h0200);
		irq(1'b0);
		// low pin inside the falling mask counts as active in logic mode
		bus(1'b1, ADDR_GLOBAL_CTRL, 32'h1);
		irq(1'b1);
		bus(1'b1, ADDR_GLOBAL_CTRL, 32'h0);
		// ce low: the new level is not even sampled until it returns
		@(posedge clk_sys);
		ce <= 1'b0;
		pins(16'h0400);
		irq(1'b0);
		@(posedge clk_sys);
		ce <= 1'b1;
		repeat (4) @(posedge clk_sys);
		irq(1'b1);
		stop_test();
	end
endmodule
